// file: core/adapter_chip_select_decoder.sv
/*
 programmable chip-select decoder of an adapter bus interface.
 assumes bus address, command strobe and option bits are synchronous to clk;
 option register file lives outside and is presented as plain bits.
*/
// Function
// - latched-address select follows input, held by strobe
// - latched-address selects excluded from card feedback
// - selects may present option bits, 16 to 24
// - selects drive unlatched 32/16 width indications
// - each range enabled by chosen option bits
// - card enable and channel check gate range-decoded selects
// - strobe from range decode and command input
// - spare address inputs usable as general inputs
// - i/o-only mode decodes a0-a15 only
// - upper inputs give 2 Kbyte blocks
`timescale 1ns/1ps
module adapter_chip_select_decoder
   import cs_decode_pkg::*;
#(
   parameter int NSEL = cs_decode_pkg::NUM_SEL,
   parameter int AW   = cs_decode_pkg::ADDR_W,
   parameter int OW   = cs_decode_pkg::OPT_W
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // bus side
   input  wire logic [AW-1:0]          busAddr,
   input  wire logic                   addr24_qualifier,
   input  wire logic                   address_latch_strobe_n,
   input  wire logic                   cmdStrobeN,
   // option bits
   input  wire logic [OW-1:0]          optBits,
   // per-select and global configuration
   input  wire logic [NSEL*2-1:0]      selMode,
   input  wire logic [NSEL*AW-1:0]     matchValue,
   input  wire logic [NSEL*AW-1:0]     matchMask,
   input  wire logic [NSEL*OW-1:0]     enableMask,
   input  wire logic [NSEL*OW-1:0]     enablePolarity,
   input  wire logic [NSEL-1:0]        feedbackInclude,
   input  wire logic [NSEL-1:0]        cmdQualify,
   input  wire logic [NSEL-1:0]        width32Sel,
   input  wire logic [NSEL*5-1:0]      latchBitSel,
   input  wire logic [NSEL*5-1:0]      optBitSel,
   input  wire logic                   ioOnly,
   input  wire logic                   gateCardEnable,
   input  wire logic                   gateChannelCheck,
   input  wire logic [NSEL-1:0]        spareUseMask,
   // outputs
   output      logic [NSEL-1:0]        select_out_n,
   output      logic                   card_selected_feedback_n,
   output      logic                   width32_indicate_n,
   output      logic                   width16_indicate_n,
   output      logic [AW-1:0]          spareInputs
);
   logic [AW-1:0]   decAddr;
   logic [NSEL-1:0] hit;
   logic [NSEL-1:0] selNext;
   logic [NSEL-1:0] latchHeld;
   logic [NSEL-1:0] fbTerm;
   logic [NSEL-1:0] w32Term;
   logic [NSEL-1:0] w16Term;
   logic            globalOk;
   logic [NSEL-1:0] selReg;

   // i/o-only decode ignores the upper address inputs
   always_comb begin
      decAddr = busAddr;
      if (ioOnly) begin
         decAddr[AW-1:IO_ADDR_W] = '0;
      end
   end

   // card disabled or channel check pending blocks range-decoded selects and width indications; latch and option selects unaffected
   assign globalOk = (!gateCardEnable || optBits[CARD_EN_BIT]) &&
                     (!gateChannelCheck || !optBits[CHCK_BIT]);

   // spare inputs pass straight through for board decode in i/o-only mode or without addr24_qualifier, else zero
   assign spareInputs = (ioOnly || !addr24_qualifier) ? busAddr : '0;

   genvar g;
   generate
      for (g = 0; g < NSEL; g++) begin : g_sel
         logic [1:0] mode;
         logic       rawHit;
         assign mode = selMode[g*2 +: 2];
         range_match #(
            .AW(AW),
            .OW(OW)
         ) u_match (
            .addr           (decAddr),
            .matchValue     (matchValue[g*AW +: AW]),
            .matchMask      (matchMask[g*AW +: AW]),
            .optBits        (optBits),
            .enableMask     (enableMask[g*OW +: OW]),
            .enablePolarity (enablePolarity[g*OW +: OW]),
            .hit            (rawHit)
         );
         // option-bit enable per range
         assign hit[g] = rawHit && globalOk && (!cmdQualify[g] || !cmdStrobeN);

         // latched address: low while chosen input low, held by strobe
         always_ff @(posedge clk) begin
            if (!rstn) begin
               latchHeld[g] <= 1'b1;
            end else if (!address_latch_strobe_n) begin
               latchHeld[g] <= busAddr[latchBitSel[g*5 +: 5]];
            end
         end

         always_comb begin
            selNext[g] = 1'b1;
            w32Term[g] = 1'b0;
            w16Term[g] = 1'b0;
            fbTerm[g]  = 1'b0;
            unique case (sel_mode_e'(mode))
               MODE_SELECT: begin
                  selNext[g] = !hit[g];
                  fbTerm[g]  = hit[g] && feedbackInclude[g];
               end
               MODE_LATCH: begin
                  selNext[g] = latchHeld[g];
               end
               MODE_OPTION: begin
                  selNext[g] = optBits[optBitSel[g*5 +: 5]];
               end
               MODE_WIDTH: begin
                  w32Term[g] = rawHit && globalOk && width32Sel[g];
                  w16Term[g] = rawHit && globalOk && !width32Sel[g];
                  selNext[g] = !(rawHit && globalOk);
               end
            endcase
         end
      end
   endgenerate

   // select outputs registered, inactive after reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         selReg <= '1;
      end else begin
         selReg <= selNext;
      end
   end

   assign select_out_n = selReg;
   // width indications are unlatched decodes
   assign width32_indicate_n       = !(|w32Term);
   assign width16_indicate_n       = !(|w16Term);
   // feedback only from plain selects marked for inclusion
   assign card_selected_feedback_n = !(|fbTerm);

   a_sel_idle: assert property (@(posedge clk) disable iff (!rstn)
      (selNext == '1) |=> (select_out_n == '1))
      else $error("select active with no decode");
   a_gate_card: assert property (@(posedge clk) disable iff (!rstn)
      (gateCardEnable && !optBits[CARD_EN_BIT]) |-> card_selected_feedback_n && width32_indicate_n)
      else $error("decode active while card disabled");
   a_gate_chck: assert property (@(posedge clk) disable iff (!rstn)
      (gateChannelCheck && optBits[CHCK_BIT]) |-> card_selected_feedback_n && width16_indicate_n)
      else $error("decode active during channel check");
   a_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
      address_latch_strobe_n |=> $stable(latchHeld))
      else $error("latched address moved without strobe");
   a_latch_take: assert property (@(posedge clk) disable iff (!rstn)
      (!address_latch_strobe_n && !busAddr[latchBitSel[4:0]]) |=> !latchHeld[0])
      else $error("latched address not captured low");
   a_fb_exclude: assert property (@(posedge clk) disable iff (!rstn)
      (selMode == {NSEL{2'(MODE_LATCH)}}) |-> card_selected_feedback_n)
      else $error("latched select reached feedback");
   a_opt_out: assert property (@(posedge clk) disable iff (!rstn)
      (selMode[1:0] == 2'(MODE_OPTION)) |=> (select_out_n[0] == $past(optBits[optBitSel[4:0]])))
      else $error("option output mismatch");
   a_cmd_qual: assert property (@(posedge clk) disable iff (!rstn)
      (cmdQualify[0] && cmdStrobeN && selMode[1:0] == 2'(MODE_SELECT)) |=> select_out_n[0])
      else $error("strobe select without command");
   a_io_only: assert property (@(posedge clk) disable iff (!rstn)
      ioOnly |-> (decAddr[AW-1:IO_ADDR_W] == '0))
      else $error("upper address used in i/o-only mode");

   c_sel_hit: cover property (@(posedge clk) disable iff (!rstn) select_out_n[0] == 1'b0);
   c_w32: cover property (@(posedge clk) disable iff (!rstn) !width32_indicate_n);
   c_w16: cover property (@(posedge clk) disable iff (!rstn) !width16_indicate_n);
   c_fb: cover property (@(posedge clk) disable iff (!rstn) !card_selected_feedback_n);
endmodule

// file: core/cs_decode_pkg.sv
/*
 constants for the adapter chip-select decoder.
 assumes a single 250 MHz clock and synchronous bus inputs.
*/
package cs_decode_pkg;
   localparam int ADDR_W        = 24;   // decoder address inputs
   localparam int NUM_SEL       = 8;    // chip-select outputs
   localparam int OPT_W         = 32;   // option register bits seen by the decoder
   localparam int IO_ADDR_W     = 16;   // i/o-only decode width
   localparam int BASE_OPT_OUT  = 16;   // dedicated option output lines
   localparam int MAX_OPT_OUT   = 24;   // with selects used as option outputs
   localparam int CARD_EN_BIT   = 0;    // card enable, option reg 0102 bit 0
   localparam int CHCK_BIT      = 31;   // channel check, option reg 0105 bit 7 (byte 3)
   localparam int BLOCK_SHIFT   = 11;   // 2 Kbyte block granularity
   localparam int LOW_FIXED     = 3;    // a0-a2 always straight from the bus
   localparam logic [1:0] MODE_RESET = 2'h0;
   typedef enum logic [1:0] {
      MODE_SELECT,
      MODE_LATCH,
      MODE_OPTION,
      MODE_WIDTH
   } sel_mode_e;
endpackage

// file: core/range_match.sv
/*
 one address range comparator with option-bit enable.
 assumes mask/value configuration is static during a bus cycle.
*/
`timescale 1ns/1ps
module range_match #(
   parameter int AW = 24,
   parameter int OW = 32
) (
   // address
   input  wire logic [AW-1:0] addr,
   // configuration
   input  wire logic [AW-1:0] matchValue,
   input  wire logic [AW-1:0] matchMask,
   input  wire logic [OW-1:0] optBits,
   input  wire logic [OW-1:0] enableMask,
   input  wire logic [OW-1:0] enablePolarity,
   // result
   output      logic          hit
);
   logic addrHit;
   logic optOk;
   assign addrHit = ((addr ^ matchValue) & matchMask) == '0;
   // every option bit selected must equal its wanted level
   assign optOk   = ((optBits ^ enablePolarity) & enableMask) == '0;
   assign hit     = addrHit & optOk;
endmodule

// file: sim/bus_host_model.sv
/*
 host bus model: registers address, command and latch strobe requests.
 assumes requests change just after a rising clk edge.
*/
`timescale 1ns/1ps
module bus_host_model (
   // clock
   input  wire logic        clk,
   // requests
   input  wire logic        reqValid,
   input  wire logic [23:0] reqAddr,
   input  wire logic        reqCmdN,
   input  wire logic        reqLatchN,
   // bus
   output      logic [23:0] busAddr,
   output      logic        cmdStrobeN,
   output      logic        address_latch_strobe_n
);
   // full address presented, board-side a3-a10 decode stays possible
   // released bus shows the inverse, strobes idle high
   always @(posedge clk) begin
      busAddr                <= reqValid ? reqAddr : ~busAddr;
      cmdStrobeN             <= reqValid ? reqCmdN : 1'b1;
      address_latch_strobe_n <= reqValid ? reqLatchN : 1'b1;
   end
endmodule

// file: sim/testbench.sv
/*
 self-checking bench for the chip-select decoder.
 assumes the host bus model presents each request one clock later.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin badCount++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   typedef struct {logic [23:0] a; logic c; logic [31:0] o; logic io; logic [7:0] s; logic [2:0] f;} row_s;
   logic         clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqCmdN = 1'b1, reqLatchN = 1'b1, ioOnly = 1'b0;
   logic [23:0]  reqAddr = 24'h0, busAddr, spareInputs;
   logic [31:0]  optBits = 32'h0;
   logic         cmdStrobeN, address_latch_strobe_n, card_selected_feedback_n, width32_indicate_n, width16_indicate_n;
   // select, latch, option, width32, width16, select
   logic [15:0]  selMode = 16'h03E4;
   logic [191:0] matchValue = '0, matchMask = '0;
   logic [255:0] enableMask = {8{32'h2}}, enablePolarity = {8{32'h2}};
   logic [7:0]   feedbackInclude = 8'h03, cmdQualify = 8'h20, width32Sel = 8'h08, select_out_n;
   logic [39:0]  latchBitSel = 40'hA0, optBitSel = 40'h2400;
   int           badCount = 0, nChecks = 0;
   row_s         rows [12] = '{
      '{24'h001234, 1'b1, 32'h1, 1'b0, 8'hFA, 3'b011}, '{24'h001234, 1'b1, 32'h201, 1'b0, 8'hFE, 3'b011},
      '{24'hAB1234, 1'b1, 32'h1, 1'b1, 8'hFA, 3'b011}, '{24'hAB1234, 1'b1, 32'h1, 1'b0, 8'hFB, 3'b111},
      '{24'h003456, 1'b1, 32'h1, 1'b0, 8'hF3, 3'b101}, '{24'h004010, 1'b1, 32'h1, 1'b0, 8'hEB, 3'b110},
      '{24'h005000, 1'b1, 32'h1, 1'b0, 8'hFB, 3'b111}, '{24'h005000, 1'b0, 32'h1, 1'b0, 8'hDB, 3'b111},
      '{24'h001234, 1'b1, 32'h0, 1'b0, 8'hFB, 3'b111}, '{24'h001234, 1'b1, 32'h80000001, 1'b0, 8'hFB, 3'b111},
      '{24'h0012FF, 1'b1, 32'h1, 1'b0, 8'hFA, 3'b011}, '{24'h001300, 1'b1, 32'h1, 1'b0, 8'hFB, 3'b111}};

   always #2 clk = ~clk;

   bus_host_model host (.clk, .reqValid, .reqAddr, .reqCmdN, .reqLatchN, .busAddr, .cmdStrobeN, .address_latch_strobe_n);

   adapter_chip_select_decoder DUT (.clk, .rstn, .busAddr, .addr24_qualifier(1'b1), .address_latch_strobe_n,
      .cmdStrobeN, .optBits, .selMode, .matchValue, .matchMask, .enableMask, .enablePolarity, .feedbackInclude,
      .cmdQualify, .width32Sel, .latchBitSel, .optBitSel, .ioOnly, .gateCardEnable(1'b1), .gateChannelCheck(1'b1),
      .spareUseMask(8'h00), .select_out_n, .card_selected_feedback_n, .width32_indicate_n, .width16_indicate_n,
      .spareInputs);

   task automatic cfg(input int i, input logic [23:0] v, input logic [23:0] m);
      matchValue[i*24+:24]     = v;
      matchMask[i*24+:24]      = m;
      enableMask[i*32+:32]     = 32'h1;
      enablePolarity[i*32+:32] = 32'h1;
   endtask

   // one request, held until both decode results have settled
   task automatic drive(input logic [23:0] a, input logic c, input logic l, input logic [31:0] o, input logic io);
      @(posedge clk);
      {reqValid, reqAddr, reqCmdN, reqLatchN, optBits, ioOnly} <= {1'b1, a, c, l, o, io};
      repeat (2) @(posedge clk);
      reqValid <= 1'b0;
      #1;
   endtask

   task automatic testDone;
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge clk);
      badCount++;
      testDone();
   end

   initial begin
      cfg(0, 24'h001200, 24'hFFFF00);
      cfg(3, 24'h003000, 24'hFFF000);
      cfg(4, 24'h004000, 24'hFFF000);
      cfg(5, 24'h005000, 24'hFFF000);
      repeat (19) @(posedge clk);
      #1;
      `CHK("select_out_n in reset", 8'hFF, select_out_n)
      @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         drive(rows[i].a, rows[i].c, 1'b1, rows[i].o, rows[i].io);
         `CHK("select_out_n", rows[i].s, select_out_n)
         `CHK("feedback and width", rows[i].f, {card_selected_feedback_n, width32_indicate_n, width16_indicate_n})
         if (rows[i].io) `CHK("spareInputs", rows[i].a, spareInputs)
      end
      // latched address: capture low, hold, capture high
      drive(24'h000000, 1'b1, 1'b0, 32'h1, 1'b0);
      `CHK("feedback with latch", 1'b1, card_selected_feedback_n)
      @(posedge clk);
      #1;
      `CHK("latched low", 1'b0, select_out_n[1])
      drive(24'h000020, 1'b1, 1'b1, 32'h1, 1'b0);
      `CHK("latch held", 1'b0, select_out_n[1])
      drive(24'h000020, 1'b1, 1'b0, 32'h1, 1'b0);
      @(posedge clk);
      #1;
      `CHK("latched high", 1'b1, select_out_n[1])
      // reset in the middle of a hit
      drive(24'h001234, 1'b1, 1'b1, 32'h1, 1'b0);
      `CHK("select_out_n before reset", 8'hFA, select_out_n)
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("select_out_n mid reset", 8'hFF, select_out_n)
      @(posedge clk);
      rstn <= 1'b1;
      drive(24'h001234, 1'b1, 1'b1, 32'h1, 1'b0);
      `CHK("select_out_n after reset", 8'hFA, select_out_n)
      testDone();
   end
endmodule
